// ===== design/osfr_core.sv
// Oscillator control register with unlock, source selection and failure recovery.
// Assumes the oscillator clocks and the external clock pin are asynchronous levels.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
module osfr_core
#(
	parameter int WDT_FAIL_CYCLES = osfr_pkg::WDT_FAIL_CYCLES
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire osfr_pkg::osfr_bus_t bus,
	output logic [7:0] rdata,
	input wire logic ipo_fast_clk,
	input wire logic ipo_slow_clk,
	input wire logic crystal_clk,
	input wire logic watchdog_osc_clk,
	input wire logic external_clock_pin,
	input wire logic [1:0] crystal_drive_option,
	output logic precision_osc_enable,
	output logic crystal_osc_enable,
	output logic watchdog_osc_enable,
	output logic crystal_pin_override,
	output logic [1:0] crystal_drive_mode,
	output logic [2:0] system_clock_select,
	output logic sysclk_fail_event,
	output logic wdt_fail_event,
	output logic clock_stopped
);
	localparam int CNT_W = $clog2(WDT_FAIL_CYCLES + 1);
	localparam logic [CNT_W-1:0] WDT_LIMIT = CNT_W'(WDT_FAIL_CYCLES);
	localparam logic [3:0] SYS_LIMIT = 4'(osfr_pkg::SYS_FAIL_WDT_TICKS);

	osfr_pkg::osfr_ctl_t oscillator_control_register;
	osfr_pkg::osfr_lock_t lock_state;
	logic [osfr_pkg::NUM_SRC-1:0] osc_raw;
	logic [osfr_pkg::NUM_SRC-1:0] osc_meta;
	logic [osfr_pkg::NUM_SRC-1:0] osc_sync;
	logic [osfr_pkg::NUM_SRC-1:0] osc_prev;
	logic [osfr_pkg::NUM_SRC-1:0] osc_rise;
	logic ctrl_wr;
	logic sel_rise;
	logic wdt_rise;
	logic sys_detect_armed;
	logic sys_fail_hit;
	logic wdt_fail_hit;
	logic sysclk_failed;
	logic wdt_failed;
	logic [3:0] sys_tick_cnt;
	logic [CNT_W-1:0] wdt_wait_cnt;
	logic next_stopped;

	// Rising edge of the currently selected source
	function automatic logic sel_edge(input logic [2:0] sel,
		input logic [osfr_pkg::NUM_SRC-1:0] rise);
		logic hit;
		hit = 1'b0;
		case (sel)
			osfr_pkg::SEL_IPO_FAST: hit = rise[osfr_pkg::SRC_IPO_FAST];
			osfr_pkg::SEL_IPO_SLOW: hit = rise[osfr_pkg::SRC_IPO_SLOW];
			osfr_pkg::SEL_CRYSTAL: hit = rise[osfr_pkg::SRC_CRYSTAL];
			osfr_pkg::SEL_WATCHDOG: hit = rise[osfr_pkg::SRC_WATCHDOG];
			osfr_pkg::SEL_EXTERNAL: hit = rise[osfr_pkg::SRC_EXTERNAL];
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// Whether the selected source is switched on
	function automatic logic sel_enabled(input osfr_pkg::osfr_ctl_t c);
		logic on;
		on = 1'b0;
		case (c.system_clock_select)
			osfr_pkg::SEL_IPO_FAST: on = c.precision_osc_enable;
			osfr_pkg::SEL_IPO_SLOW: on = c.precision_osc_enable;
			osfr_pkg::SEL_CRYSTAL: on = c.crystal_osc_enable;
			osfr_pkg::SEL_WATCHDOG: on = c.watchdog_osc_enable;
			osfr_pkg::SEL_EXTERNAL: on = 1'b1;
			default: on = 1'b0;
		endcase
		return on;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator level synchronisers

	assign osc_raw = {external_clock_pin, watchdog_osc_clk, crystal_clk, ipo_slow_clk,
		ipo_fast_clk};

	genvar gi;
	generate
		for (gi = 0; gi < osfr_pkg::NUM_SRC; gi++)
		begin : g_sync
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
				begin
					osc_meta[gi] <= 1'b0;
					osc_sync[gi] <= 1'b0;
					osc_prev[gi] <= 1'b0;
				end
				else
				begin
					osc_meta[gi] <= osc_raw[gi];
					osc_sync[gi] <= osc_meta[gi];
					osc_prev[gi] <= osc_sync[gi];
				end
			end
			assign osc_rise[gi] = osc_sync[gi] & ~osc_prev[gi];
		end
	endgenerate

	assign sel_rise = sel_edge(oscillator_control_register.system_clock_select, osc_rise);
	assign wdt_rise = osc_rise[osfr_pkg::SRC_WATCHDOG];

	////////////////////////////////////////////////////////////////////////////////
	// Unlock sequencer

	assign ctrl_wr = bus.wr && (bus.addr == osfr_pkg::CTRL_ADDR);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			lock_state <= osfr_pkg::LOCK_IDLE;
		else if (ctrl_wr)
		begin
			// Only writes to this address move the sequence
			case (lock_state)
				osfr_pkg::LOCK_IDLE:
					if (bus.wdata == osfr_pkg::KEY_FIRST)
						lock_state <= osfr_pkg::LOCK_KEY1;
				osfr_pkg::LOCK_KEY1:
					if (bus.wdata == osfr_pkg::KEY_SECOND)
						lock_state <= osfr_pkg::LOCK_OPEN;
					else
						lock_state <= osfr_pkg::LOCK_IDLE;
				osfr_pkg::LOCK_OPEN:
					lock_state <= osfr_pkg::LOCK_IDLE;
				default:
					lock_state <= osfr_pkg::LOCK_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register and automatic switch-over

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			oscillator_control_register <= osfr_pkg::CTRL_RESET;
		else if (ctrl_wr && lock_state == osfr_pkg::LOCK_OPEN)
			oscillator_control_register <= bus.wdata;
		else if (sys_fail_hit)
			oscillator_control_register.system_clock_select <= osfr_pkg::SEL_WATCHDOG;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Primary clock failure: count watchdog ticks between selected clock edges

	// Needs the watchdog oscillator running and healthy
	assign sys_detect_armed = oscillator_control_register.sysclk_fail_detect_enable &&
		oscillator_control_register.watchdog_osc_enable && !wdt_failed;
	assign sys_fail_hit = sys_detect_armed && !sel_rise && wdt_rise &&
		(sys_tick_cnt == SYS_LIMIT - 4'h1);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sys_tick_cnt <= 4'h0;
		else if (!sys_detect_armed || sel_rise || sys_fail_hit)
			sys_tick_cnt <= 4'h0;
		else if (wdt_rise)
			sys_tick_cnt <= sys_tick_cnt + 4'h1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sysclk_failed <= 1'b0;
			sysclk_fail_event <= 1'b0;
		end
		else
		begin
			sysclk_fail_event <= sys_fail_hit;
			if (sys_fail_hit)
				sysclk_failed <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog oscillator failure: count core clocks between watchdog edges

	assign wdt_fail_hit = oscillator_control_register.watchdog_osc_fail_detect_enable &&
		!wdt_failed && !wdt_rise && (wdt_wait_cnt == WDT_LIMIT - CNT_W'(1));

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			wdt_wait_cnt <= '0;
		else if (!oscillator_control_register.watchdog_osc_fail_detect_enable || wdt_rise
			|| wdt_fail_hit)
			wdt_wait_cnt <= '0;
		else if (!wdt_failed)
			wdt_wait_cnt <= wdt_wait_cnt + CNT_W'(1);
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wdt_failed <= 1'b0;
			wdt_fail_event <= 1'b0;
		end
		else
		begin
			// Event only; the select is left alone
			wdt_fail_event <= wdt_fail_hit;
			if (wdt_fail_hit)
				wdt_failed <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stopped device: selected source off and no recovery path

	assign next_stopped = clock_stopped ||
		(!sel_enabled(oscillator_control_register) && !sys_detect_armed);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			clock_stopped <= 1'b0;
		else
			clock_stopped <= next_stopped;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator enables and selection outputs

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			precision_osc_enable <= 1'b0;
			crystal_osc_enable <= 1'b0;
			watchdog_osc_enable <= 1'b0;
			crystal_pin_override <= 1'b0;
			system_clock_select <= 3'h0;
			crystal_drive_mode <= 2'h0;
		end
		else
		begin
			precision_osc_enable <= oscillator_control_register.precision_osc_enable;
			crystal_osc_enable <= oscillator_control_register.crystal_osc_enable;
			crystal_pin_override <= oscillator_control_register.crystal_osc_enable;
			watchdog_osc_enable <= oscillator_control_register.watchdog_osc_enable;
			// Selected source drives the system clock undivided
			system_clock_select <= oscillator_control_register.system_clock_select;
			crystal_drive_mode <= crystal_drive_option;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read port

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (bus.rd && bus.addr == osfr_pkg::CTRL_ADDR)
			rdata <= oscillator_control_register;
		else if (bus.rd && bus.addr == osfr_pkg::STATUS_ADDR)
		begin
			rdata <= 8'h00;
			rdata[osfr_pkg::STAT_SYS_FAIL_BIT] <= sysclk_failed;
			rdata[osfr_pkg::STAT_WDT_FAIL_BIT] <= wdt_failed;
			rdata[osfr_pkg::STAT_STOPPED_BIT] <= clock_stopped;
		end
		else
			rdata <= 8'h00;
	end
endmodule

// ===== inc/osfr_pkg.sv
// Constants and types for the oscillator select and failure recovery block.
// Assumes one core clock at 20 MHz and oscillator clocks arriving as asynchronous levels.
package osfr_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] CTRL_ADDR = 12'hf86;
	localparam logic [11:0] STATUS_ADDR = 12'hf8f;
	localparam logic [7:0] KEY_FIRST = 8'he7;
	localparam logic [7:0] KEY_SECOND = 8'h18;
	localparam logic [7:0] CTRL_RESET = 8'ha0;
	localparam int STAT_SYS_FAIL_BIT = 0;
	localparam int STAT_WDT_FAIL_BIT = 1;
	localparam int STAT_STOPPED_BIT = 2;
	localparam logic [2:0] SEL_IPO_FAST = 3'h0;
	localparam logic [2:0] SEL_IPO_SLOW = 3'h1;
	localparam logic [2:0] SEL_CRYSTAL = 3'h2;
	localparam logic [2:0] SEL_WATCHDOG = 3'h3;
	localparam logic [2:0] SEL_EXTERNAL = 3'h4;
	localparam int SRC_IPO_FAST = 0;
	localparam int SRC_IPO_SLOW = 1;
	localparam int SRC_CRYSTAL = 2;
	localparam int SRC_WATCHDOG = 3;
	localparam int SRC_EXTERNAL = 4;
	localparam int NUM_SRC = 5;
	localparam int SYSCLK_FAIL_HZ = 1000;
	localparam int WDT_OSC_HZ = 10000;
	localparam int SYS_FAIL_WDT_TICKS = WDT_OSC_HZ / SYSCLK_FAIL_HZ;
	localparam int WDT_FAIL_CYCLES = 8004;

	typedef struct packed
	{
		logic precision_osc_enable;
		logic crystal_osc_enable;
		logic watchdog_osc_enable;
		logic sysclk_fail_detect_enable;
		logic watchdog_osc_fail_detect_enable;
		logic [2:0] system_clock_select;
	} osfr_ctl_t;

	typedef struct packed
	{
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} osfr_bus_t;

	typedef enum logic [2:0]
	{
		LOCK_IDLE = 3'b001,
		LOCK_KEY1 = 3'b010,
		LOCK_OPEN = 3'b100
	} osfr_lock_t;
endpackage

// ===== tb/osfr_core_props.sv
// Checker on the oscillator control block ports.
// Assumes the block is reset before use.
`timescale 1ns/100ps
module osfr_core_props
#(
	parameter int WDT_FAIL_CYCLES = 8004
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire osfr_pkg::osfr_bus_t bus,
	input wire logic watchdog_osc_clk,
	input wire logic crystal_osc_enable,
	input wire logic watchdog_osc_enable,
	input wire logic crystal_pin_override,
	input wire logic [2:0] system_clock_select,
	input wire logic sysclk_fail_event,
	input wire logic wdt_fail_event,
	input wire logic clock_stopped
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic wd_q;
	logic wdt_seen;
	int quiet;
	////////////////////////////////////////////////////////////////
	// Cycles since the last watchdog oscillator rise
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			wd_q <= 1'b0;
			quiet <= 0;
		end
		else
		begin
			wd_q <= watchdog_osc_clk;
			quiet <= (watchdog_osc_clk && !wd_q) ? 0 : quiet + 1;
		end
	end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			wdt_seen <= 1'b0;
		else if (wdt_fail_event)
			wdt_seen <= 1'b1;
	end
	////////////////////////////////////////////////////////////////
	property p_ovr; crystal_pin_override == crystal_osc_enable; endproperty
	a_ovr: assert property (p_ovr) else $error("pin override off");
	property p_sel; sysclk_fail_event |=> system_clock_select == 3'h3; endproperty
	a_sel: assert property (p_sel) else $error("no switch");
	property p_pulse; sysclk_fail_event |=> !sysclk_fail_event; endproperty
	a_pulse: assert property (p_pulse) else $error("event too long");
	property p_wen; sysclk_fail_event |-> watchdog_osc_enable; endproperty
	a_wen: assert property (p_wen) else $error("switch without osc");
	property p_keep; wdt_fail_event |=> $stable(system_clock_select); endproperty
	a_keep: assert property (p_keep) else $error("select moved");
	property p_after; sysclk_fail_event |-> !wdt_seen; endproperty
	a_after: assert property (p_after) else $error("detect after loss");
	property p_quiet; wdt_fail_event |-> quiet >= WDT_FAIL_CYCLES; endproperty
	a_quiet: assert property (p_quiet) else $error("loss too early");
	property p_once; wdt_fail_event |-> !wdt_seen; endproperty
	a_once: assert property (p_once) else $error("second loss");
	property p_stop; clock_stopped |=> clock_stopped; endproperty
	a_stop: assert property (p_stop) else $error("stop cleared");
	property p_selsrc;
		$changed(system_clock_select) |->
			($past(bus.wr, 2) && $past(bus.addr, 2) == osfr_pkg::CTRL_ADDR) ||
			$past(sysclk_fail_event);
	endproperty
	a_selsrc: assert property (p_selsrc) else $error("select moved alone");
	c_sys: cover property (sysclk_fail_event);
	c_wdt: cover property (wdt_fail_event);
	c_stop: cover property ($rose(clock_stopped));
endmodule
bind osfr_core osfr_core_props #(.WDT_FAIL_CYCLES(WDT_FAIL_CYCLES)) u_props (
	.core_clk(core_clk), .rst(rst), .bus(bus), .watchdog_osc_clk(watchdog_osc_clk),
	.crystal_osc_enable(crystal_osc_enable), .watchdog_osc_enable(watchdog_osc_enable),
	.crystal_pin_override(crystal_pin_override), .system_clock_select(system_clock_select),
	.sysclk_fail_event(sysclk_fail_event), .wdt_fail_event(wdt_fail_event),
	.clock_stopped(clock_stopped));

// ===== tb/osfr_osc_model.sv
// Behavioural oscillators for the clock inputs.
// Assumes a source toggles only while run is high.
`timescale 1ns/100ps
module osfr_osc_model
(
	input wire logic [4:0] run,
	output logic [4:0] osc
);
	initial osc = 5'h00;
	for (genvar i = 0; i < 5; i++)
	begin : g_src
		always
		begin
			#(i == 3 ? 500 : 70 + 10 * i);
			osc[i] = run[i] ? !osc[i] : osc[i];
		end
	end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the oscillator control block.
// Assumes the oscillator model and the bound checker.
`timescale 1ns/100ps
module testbench;
	localparam logic [11:0] CA = osfr_pkg::CTRL_ADDR;
	localparam logic [11:0] SA = osfr_pkg::STATUS_ADDR;
	localparam logic [7:0] BAD [6] = '{8'h55, 8'h18, 8'he7, 8'he7, 8'h18, 8'h41};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	osfr_pkg::osfr_bus_t bus = '0;
	logic [4:0] osc;
	logic [4:0] kill = 5'h00;
	logic [1:0] crystal_drive_option = 2'h0;
	logic [7:0] rdata;
	logic [2:0] system_clock_select;
	logic [1:0] crystal_drive_mode;
	logic precision_osc_enable, crystal_osc_enable, watchdog_osc_enable, crystal_pin_override;
	logic sysclk_fail_event, wdt_fail_event, clock_stopped;
	int fail_count = 0;
	int n_checks = 0;
	int ctrl_m = 'ha0;
	int lk = 0;
	bit hit;
	always #25 core_clk = !core_clk;
	osfr_osc_model osc_u (.run(~kill & {1'b1, watchdog_osc_enable, crystal_osc_enable,
		{2{precision_osc_enable}}}), .osc(osc));
	osfr_core #(.WDT_FAIL_CYCLES(40)) dut_u (.core_clk, .rst, .bus, .rdata,
		.ipo_fast_clk(osc[0]), .ipo_slow_clk(osc[1]), .crystal_clk(osc[2]),
		.watchdog_osc_clk(osc[3]), .external_clock_pin(osc[4]), .crystal_drive_option,
		.precision_osc_enable, .crystal_osc_enable, .watchdog_osc_enable, .crystal_pin_override,
		.crystal_drive_mode, .system_clock_select, .sysclk_fail_event, .wdt_fail_event,
		.clock_stopped);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
		if (a == CA && lk == 2)
			ctrl_m = d;
		if (a == CA)
			lk = (lk == 0 && d == 8'he7) ? 1 : (lk == 1 && d == 8'h18) ? 2 : 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		chk("rdata", rdata, exp);
	endtask
	task automatic unl(input logic [7:0] d);
		wr(CA, 8'he7);
		rd(12'h100 + 12'($urandom % 256), 8'h00);
		wr(CA, 8'h18);
		wr(CA, d);
	endtask
	task automatic wev(input bit w, input int n, input bit must);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++)
		begin
			@(posedge core_clk);
			#1;
			hit = (w ? wdt_fail_event : sysclk_fail_event) === 1'b1;
		end
		chk(w ? "wdt_event" : "sys_event", {7'h00, hit}, {7'h00, must});
		if (must && !hit)
			wrap_up();
	endtask
	task automatic chk_out;
		chk("outputs", {precision_osc_enable, crystal_osc_enable, watchdog_osc_enable,
			crystal_pin_override, 1'b0, system_clock_select},
			(8'(ctrl_m) & 8'he7) | ((8'(ctrl_m) >> 2) & 8'h10));
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(32'h1133_bd12));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		rd(CA, 8'ha0);
		chk_out();
		rd(SA, 8'h00);
		foreach (BAD[i]) wr(CA, BAD[i]);
		rd(CA, 8'ha0);
		for (int s = 0; s < 5; s++)
		begin
			@(posedge core_clk);
			crystal_drive_option <= 2'($urandom);
			unl(8'he0 | 8'(s));
			wr(CA, 8'h07);
			rd(CA, 8'(ctrl_m));
			chk_out();
			chk("drive", {6'h00, crystal_drive_mode}, {6'h00, crystal_drive_option});
		end
		unl(8'he2);
		kill[2] <= 1'b1;
		unl(8'hd2);
		wev(0, 400, 0);
		unl(8'hf2);
		wev(0, 1000, 1);
		ctrl_m = 'hf3;
		repeat (100) @(posedge core_clk);
		rd(CA, 8'hf3);
		chk_out();
		rd(SA, 8'h01);
		unl(8'he3);
		unl(8'he0);
		unl(8'he8);
		wev(1, 200, 0);
		@(posedge core_clk);
		kill[3] <= 1'b1;
		wev(1, 200, 1);
		rd(SA, 8'h03);
		chk_out();
		@(posedge core_clk);
		kill[3] <= 1'b0;
		unl(8'he2);
		unl(8'hf2);
		wev(0, 400, 0);
		unl(8'he2);
		unl(8'h20);
		repeat (4) @(posedge core_clk);
		unl(8'ha0);
		rd(SA, 8'h07);
		chk("stopped", {7'h00, clock_stopped}, 8'h01);
		@(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		ctrl_m = 'ha0;
		lk = 0;
		rd(CA, 8'ha0);
		chk("stopped", {7'h00, clock_stopped}, 8'h00);
		wrap_up();
	end
endmodule
